//--- hw/iso_core.sv
// Operation
// - Decode 0011 11df ffff as increment-skip.
// - Increment file; d picks destination; zero flag untouched.
// - Zero result discards next word as no-op.
// - OR literal into accumulator, update zero.
// - Decode 1101 kkkk kkkk as OR literal.
// - Decode 0001 00df ffff; OR accumulator, file.
// - OR-file updates zero, one word, one cycle.
//
// The implementer's own choices: register access over Wishbone and the register offsets.
module iso_core (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  logic ack_q;
  logic [31:0] rdat_q;
  logic [7:0] acc_q;
  logic zero_q;
  logic skip_q;
  logic [15:0] cycles_q;
  logic [7:0] file_q [iso_pkg::ISO_FILE_DEPTH];

  logic req;
  logic wr_go;
  logic is_file;
  logic [4:0] bus_fidx;
  logic issue;
  logic exec;
  logic is_inc_skip;
  logic is_or_lit;
  logic is_or_file;
  logic dest_file;
  logic [4:0] faddr;
  logic [7:0] literal;
  logic [7:0] fval;
  logic [7:0] inc_sum;
  logic [7:0] or_lit_res;
  logic [7:0] or_file_res;

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // A request is answered one cycle after it is seen; writes land at the ack edge.
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr_go = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0];
  assign is_file = wb_adr_i[iso_pkg::ISO_FILE_SEL_BIT];
  assign bus_fidx = wb_adr_i[6:2];
  // An instruction needs both low byte lanes, since the word spans twelve bits.
  assign issue = wr_go && wb_sel_i[1] && !is_file && (wb_adr_i == iso_pkg::ISO_REG_INSTR);
  // A word issued while a skip is pending is the cancelled prefetch.
  assign exec = issue && !skip_q;

  iso_decode u_decode (
    .word(wb_dat_i[11:0]),
    .is_inc_skip(is_inc_skip),
    .is_or_lit(is_or_lit),
    .is_or_file(is_or_file),
    .dest_file(dest_file),
    .faddr(faddr),
    .literal(literal)
  );

  assign fval = file_q[faddr];
  assign inc_sum = 8'(fval + 8'h01);
  assign or_lit_res = acc_q | literal;
  assign or_file_res = acc_q | fval;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdat_q <= 32'h0000_0000;
    end else if (req) begin
      rdat_q <= 32'h0000_0000;
      if (is_file) begin
        rdat_q[7:0] <= file_q[bus_fidx];
      end else begin
        unique case (wb_adr_i)
          iso_pkg::ISO_REG_ACC: rdat_q[7:0] <= acc_q;
          iso_pkg::ISO_REG_STATUS: begin
            rdat_q[iso_pkg::ISO_ST_ZERO_BIT] <= zero_q;
            rdat_q[iso_pkg::ISO_ST_SKIP_BIT] <= skip_q;
          end
          iso_pkg::ISO_REG_CYCLES: rdat_q[15:0] <= cycles_q;
          default: rdat_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Accumulator: software writes, OR-literal results, or other results with destination bit clear.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= iso_pkg::ISO_ACC_RST;
    end else if (wr_go && !is_file && (wb_adr_i == iso_pkg::ISO_REG_ACC)) begin
      acc_q <= wb_dat_i[7:0];
    end else if (exec && is_inc_skip && !dest_file) begin
      acc_q <= inc_sum;
    end else if (exec && is_or_lit) begin
      acc_q <= or_lit_res;
    end else if (exec && is_or_file && !dest_file) begin
      acc_q <= or_file_res;
    end
  end

  // File registers: software writes, or results with destination bit set.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < iso_pkg::ISO_FILE_DEPTH; i++) begin
        file_q[i] <= iso_pkg::ISO_FILE_RST;
      end
    end else if (wr_go && is_file) begin
      file_q[bus_fidx] <= wb_dat_i[7:0];
    end else if (exec && is_inc_skip && dest_file) begin
      file_q[faddr] <= inc_sum;
    end else if (exec && is_or_file && dest_file) begin
      file_q[faddr] <= or_file_res;
    end
  end

  // Zero flag; the increment-skip leaves it alone.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      zero_q <= 1'b0;
    end else if (wr_go && !is_file && (wb_adr_i == iso_pkg::ISO_REG_STATUS)) begin
      zero_q <= wb_dat_i[iso_pkg::ISO_ST_ZERO_BIT];
    end else if (exec && is_or_lit) begin
      zero_q <= (or_lit_res == 8'h00);
    end else if (exec && is_or_file) begin
      zero_q <= (or_file_res == 8'h00);
    end
  end

  // Pending skip: armed by a zero increment, consumed by the next issued word.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      skip_q <= 1'b0;
    end else if (exec && is_inc_skip) begin
      skip_q <= (inc_sum == 8'h00);
    end else if (issue) begin
      skip_q <= 1'b0;
    end
  end

  // Each issued word, executed or discarded, is one instruction cycle.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cycles_q <= iso_pkg::ISO_CYCLES_RST;
    end else if (issue) begin
      cycles_q <= cycles_q + iso_pkg::ISO_CYCLE_STEP;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_zero_inc;
    exec && is_inc_skip && (inc_sum == 8'h00);
  endsequence

  // The first word issued while a skip is pending is the one that must be dropped.
  sequence s_next_word;
    skip_q && issue;
  endsequence

  inc_decode_a: assert property (
    issue && (wb_dat_i[11:6] == 6'h0f) |-> is_inc_skip && !is_or_file && !is_or_lit)
    else $error("increment-skip pattern not decoded");

  inc_to_acc_a: assert property (
    exec && is_inc_skip && !dest_file |=> acc_q == $past(inc_sum) && zero_q == $past(zero_q))
    else $error("increment result or zero flag wrong");

  inc_to_file_a: assert property (
    exec && is_inc_skip && dest_file |=> acc_q == $past(acc_q) && skip_q == ($past(inc_sum) == 8'h00))
    else $error("increment to file disturbed accumulator or skip");

  skip_arm_a: assert property (
    s_zero_inc |=> skip_q)
    else $error("zero increment did not arm the skip");

  skip_discard_a: assert property (
    s_next_word |=> acc_q == $past(acc_q) && !skip_q
      && zero_q == $past(zero_q))
    else $error("word after zero increment was not discarded");

  orl_result_a: assert property (
    exec && is_or_lit |=> acc_q == $past(or_lit_res) && zero_q == ($past(or_lit_res) == 8'h00))
    else $error("OR literal result wrong");

  orl_decode_a: assert property (
    issue && (wb_dat_i[11:8] == 4'hd) |-> is_or_lit && literal == wb_dat_i[7:0])
    else $error("OR literal pattern not decoded");

  orf_result_a: assert property (
    exec && is_or_file && !dest_file |=> acc_q == $past(or_file_res))
    else $error("OR file result wrong");

  orf_cycle_a: assert property (
    issue |=> cycles_q == 16'($past(cycles_q) + 16'h0001))
    else $error("instruction cycle count wrong");

  zero_flag_a: assert property (
    exec && is_or_file |=> zero_q == ($past(or_file_res) == 8'h00))
    else $error("zero flag does not follow result");

  ack_pulse_a: assert property (
    ack_q |=> !ack_q)
    else $error("ack held longer than one cycle");

endmodule : iso_core

//--- hw/iso_pkg.sv
package iso_pkg;

  // Register byte offsets on the Wishbone bus.
  localparam logic [7:0] ISO_REG_INSTR = 8'h00;
  localparam logic [7:0] ISO_REG_ACC = 8'h04;
  localparam logic [7:0] ISO_REG_STATUS = 8'h08;
  localparam logic [7:0] ISO_REG_CYCLES = 8'h0c;
  // File registers occupy 0x80..0xfc, one word each; address bit 7 selects them.
  localparam int ISO_FILE_SEL_BIT = 7;
  localparam int ISO_FILE_DEPTH = 32;

  // Status field positions.
  localparam int ISO_ST_ZERO_BIT = 0;
  localparam int ISO_ST_SKIP_BIT = 1;

  // Instruction word layout.
  localparam int ISO_WORD_W = 12;
  localparam int ISO_DEST_BIT = 5;
  localparam logic [5:0] ISO_OP_INC_SKIP = 6'h0f;
  localparam logic [5:0] ISO_OP_OR_FILE = 6'h04;
  localparam logic [3:0] ISO_OP_OR_LIT = 4'hd;

  // Values after reset.
  localparam logic [7:0] ISO_ACC_RST = 8'h00;
  localparam logic [7:0] ISO_FILE_RST = 8'h00;
  localparam logic [15:0] ISO_CYCLES_RST = 16'h0000;
  // One instruction cycle per issued word.
  localparam logic [15:0] ISO_CYCLE_STEP = 16'h0001;

endpackage : iso_pkg

//--- hw/iso_decode.sv
module iso_decode (
  // Instruction word
  input wire logic [11:0] word,
  // Decoded fields
  output logic is_inc_skip,
  output logic is_or_lit,
  output logic is_or_file,
  output logic dest_file,
  output logic [4:0] faddr,
  output logic [7:0] literal
);

  always_comb begin
    is_inc_skip = (word[11:6] == iso_pkg::ISO_OP_INC_SKIP);
    is_or_file = (word[11:6] == iso_pkg::ISO_OP_OR_FILE);
    is_or_lit = (word[11:8] == iso_pkg::ISO_OP_OR_LIT);
    dest_file = word[iso_pkg::ISO_DEST_BIT];
    faddr = word[4:0];
    literal = word[7:0];
  end

endmodule : iso_decode

//--- sim/tb_iso_core.sv
module tb_iso_core;
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk;
  logic rst_n;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_we_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [31:0] rdata;
  logic [31:0] cyc_exp;
  int bad_count;
  int n_compared;
  int tick = 0;

  iso_core i_iso_core (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o)
  );

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  // The limit covers every access with a wide margin; running into it means a lost ack.
  always @(posedge core_clk) begin
    tick <= tick + 1;
    if (tick == 2000) begin
      bad_count++;
      $display("FAIL %0t timeout", $time);
      final_report();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Entered just after a rising edge; holds the request until the edge that samples ack.
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] sel);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= sel;
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    rdata = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf);
    check(rdata, e);
  endtask : rd_chk

  task automatic issue(input logic [11:0] w);
    wr(iso_pkg::ISO_REG_INSTR, {20'h0, w});
    cyc_exp = cyc_exp + 32'h1;
  endtask : issue

  function automatic logic [7:0] fa(input logic [4:0] f);
    return {1'b1, f, 2'b00};
  endfunction : fa

  initial begin
    rst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    cyc_exp = 32'h0;
    bad_count = 0;
    n_compared = 0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd_chk(iso_pkg::ISO_REG_ACC, 32'h0);
    rd_chk(iso_pkg::ISO_REG_STATUS, 32'h0);
    rd_chk(iso_pkg::ISO_REG_CYCLES, 32'h0);
    $display("test reset done");
    wr(iso_pkg::ISO_REG_ACC, 32'h9a);
    issue({4'hd, 8'h35});
    rd_chk(iso_pkg::ISO_REG_ACC, 32'hbf);
    rd_chk(iso_pkg::ISO_REG_STATUS, 32'h0);
    wr(iso_pkg::ISO_REG_ACC, 32'h0);
    issue({4'hd, 8'h00});
    rd_chk(iso_pkg::ISO_REG_STATUS, 32'h1);
    issue({4'hd, 8'hff});
    rd_chk(iso_pkg::ISO_REG_ACC, 32'hff);
    rd_chk(iso_pkg::ISO_REG_STATUS, 32'h0);
    $display("test or literal done");
    wr(fa(5'd31), 32'h0f);
    wr(iso_pkg::ISO_REG_ACC, 32'h30);
    issue({6'h04, 1'b0, 5'd31});
    rd_chk(iso_pkg::ISO_REG_ACC, 32'h3f);
    rd_chk(fa(5'd31), 32'h0f);
    wr(iso_pkg::ISO_REG_ACC, 32'hc0);
    issue({6'h04, 1'b1, 5'd31});
    rd_chk(fa(5'd31), 32'hcf);
    rd_chk(iso_pkg::ISO_REG_ACC, 32'hc0);
    wr(iso_pkg::ISO_REG_ACC, 32'h0);
    issue({6'h04, 1'b1, 5'd0});
    rd_chk(iso_pkg::ISO_REG_STATUS, 32'h1);
    issue(12'h160);
    rd_chk(iso_pkg::ISO_REG_ACC, 32'h0);
    $display("test or file done");
    wr(fa(5'd7), 32'h41);
    issue({6'h0f, 1'b0, 5'd7});
    rd_chk(iso_pkg::ISO_REG_ACC, 32'h42);
    rd_chk(fa(5'd7), 32'h41);
    rd_chk(iso_pkg::ISO_REG_STATUS, 32'h1);
    wr(iso_pkg::ISO_REG_STATUS, 32'h0);
    wr(fa(5'd2), 32'hff);
    issue({6'h0f, 1'b1, 5'd2});
    rd_chk(fa(5'd2), 32'h0);
    rd_chk(iso_pkg::ISO_REG_STATUS, 32'h2);
    issue({4'hd, 8'h01});
    rd_chk(iso_pkg::ISO_REG_ACC, 32'h42);
    rd_chk(iso_pkg::ISO_REG_STATUS, 32'h0);
    rd_chk(iso_pkg::ISO_REG_CYCLES, cyc_exp);
    $display("test increment skip done");
    wr(iso_pkg::ISO_REG_CYCLES, 32'h55);
    bus(1'b1, iso_pkg::ISO_REG_INSTR, {20'h0, 4'hd, 8'h80}, 4'h1);
    rd_chk(iso_pkg::ISO_REG_ACC, 32'h42);
    rd_chk(iso_pkg::ISO_REG_CYCLES, cyc_exp);
    rd_chk(8'h40, 32'h0);
    $display("test refused access done");
    final_report();
  end
endmodule : tb_iso_core
